// *** test/fconv_sva.sv ***
// Checker for the converter's bus handshake, done pulse and interrupt.
// Assumes it is bound to the top module; one clock, reset active low.
module fconv_sva
    import fconv_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic [4:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic IRQ,
    input wire logic DONE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK_SYS);
    endclocking
    default disable iff (!RSTN);
    // Accepted bus cycles; a command counts only with a known code and lanes 0 and 1
    wire wr_acc = AVS_WRITE && !AVS_WAITREQUEST;
    wire cmd_acc = wr_acc && AVS_ADDRESS == OFF_CMD && AVS_BYTEENABLE[1:0] == 2'h3
        && AVS_WRITEDATA[8:0] >= OP_FLOAT_TO_INT16 && AVS_WRITEDATA[8:0] <= OP_INT32_TO_FLOAT;
    a_wait_one_cycle: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
        |=> !AVS_WAITREQUEST)
        else $error("waitrequest not low one cycle after request");
    a_wait_low_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low for more than one cycle");
    a_done_single: assert property (DONE |=> !DONE)
        else $error("done longer than one cycle");
    a_done_after_cmd: assert property (cmd_acc |-> ##2 DONE)
        else $error("done missing two cycles after command");
    a_done_has_cause: assert property (DONE |-> $past(cmd_acc, 2))
        else $error("done without an accepted command");
    a_irq_rise_cause: assert property ($rose(IRQ) |-> DONE || $past(DONE)
        || $past(wr_acc))
        else $error("interrupt rose without event or write");
    a_irq_fall_write: assert property ($fell(IRQ) |-> $past(wr_acc)
        || $past(wr_acc, 2))
        else $error("interrupt fell without a write");
    a_flag_upper_zero: assert property (AVS_READ && !AVS_WAITREQUEST
        && AVS_ADDRESS == OFF_FLAGS |-> AVS_READDATA[31:3] == 29'h0)
        else $error("flag word upper bits not zero");
    // Main scenarios reached
    c_command: cover property (cmd_acc);
    c_done: cover property (DONE ##1 !DONE);
    c_irq: cover property ($rose(IRQ));
endmodule // fconv_sva

// *** test/float_int_converter_bench.sv ***
// Self-checking bench for the converter against an integer model.
// Assumes the sequencer model drives the bus; clock 40 MHz.
module float_int_converter_bench
    import fconv_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [4:0] adr;
    logic rd_en, wr_en, wreq, irq, done;
    logic [31:0] wdat, rdat, got;
    logic [3:0] ben;
    logic [15:0] lo_m = 16'h0, hi_m = 16'h0;
    logic [33:0] p;
    int failures = 0;
    int total_checks = 0;
    // Op index (0..3 from code 450) and source word
    logic [33:0] plan[$] = '{{2'd0, 32'h40600000}, {2'd0, 32'hc0600000}, {2'd0, 32'h46ffff00},
        {2'd0, 32'h47000000}, {2'd0, 32'hc7000080}, {2'd0, 32'hc7000100}, {2'd0, 32'h7fc00000},
        {2'd0, 32'h80000000}, {2'd0, 32'h3f000000}, {2'd1, 32'h4effffff}, {2'd1, 32'h4f000000},
        {2'd1, 32'hcf000000}, {2'd1, 32'h7f800000}, {2'd1, 32'hffc00001}, {2'd2, 32'h5a5a0003},
        {2'd2, 32'h0000fffd}, {2'd2, 32'ha5a58000}, {2'd2, 32'h00007fff}, {2'd3, 32'h00ffffff},
        {2'd3, 32'hff000001}, {2'd3, 32'h01000001}, {2'd3, 32'h01000003}, {2'd3, 32'h80000000},
        {2'd3, 32'h7fffffff}};
    always #12.5 clk_sys = ~clk_sys;
    seq_master seq (.clk(clk_sys), .waitrequest(wreq), .readdata(rdat), .address(adr),
        .read(rd_en), .write(wr_en), .writedata(wdat), .byteenable(ben));
    float_int_converter DUT (.CLK_SYS(clk_sys), .RSTN(rstn), .AVS_ADDRESS(adr),
        .AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(ben),
        .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq), .IRQ(irq), .DONE(done));
    task automatic end_of_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic hang;
        failures++;
        end_of_test();
    endtask
    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] seen);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic seen);
        chk_word(what, 32'(exp), 32'(seen));
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bit to;
        seq.xfer(1'b1, a, d, q, to);
        if (to) hang();
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] q);
        bit to;
        seq.xfer(1'b0, a, 32'h0, q, to);
        if (to) hang();
    endtask
    // Truncate toward zero; saturate and flag out of range, NaN gives zero
    function automatic longint f2i(input logic [31:0] f, input bit w32, output bit err);
        longint m, lo;
        int e;
        e = f[30:23];
        lo = w32 ? -64'sh80000000 : -64'sh8000;
        err = e == 255 && f[22:0] != 0;
        if (err) return 0;
        m = {1'b1, f[22:0]};
        if (e < 127) m = 0;
        else if (e > 189) m = 64'sh10000000000;
        else m = e >= 150 ? m << (e - 150) : m >> (150 - e);
        if (f[31]) m = -m;
        if (m < lo || m > -lo - 1) err = 1;
        return m < lo ? lo : (m > -lo - 1 ? -lo - 1 : m);
    endfunction
    // Round to nearest, ties to an even last fraction bit
    function automatic logic [31:0] i2f(input longint v);
        longint m, r, h;
        int e;
        m = v < 0 ? -v : v;
        if (m == 0) return 32'h0;
        for (e = 40; m[e] == 1'b0; e--);
        if (e <= 23) return {v < 0, 8'(e + 127), 23'(m << (23 - e))};
        r = m & ((64'sd1 << (e - 23)) - 1);
        h = 64'sd1 << (e - 24);
        m = m >> (e - 23);
        if (r > h || (r == h && m[0])) m++;
        if (m[24]) e++;
        return {v < 0, 8'(e + 127), m[24] ? 23'(m >> 1) : m[22:0]};
    endfunction
    // One conversion through the registers, checked word by word
    task automatic run(input logic [33:0] q);
        logic [31:0] f, v;
        longint r;
        bit err;
        logic [2:0] fl;
        v = q[31:0];
        wr(OFF_SRC_LO, {16'h0, v[15:0]});
        wr(OFF_SRC_HI, {16'h0, v[31:16]});
        wr(OFF_CMD, {23'h0, OP_FLOAT_TO_INT16 + 9'(q[33:32])});
        for (int n = 0; n < 8 && done !== 1'b1; n++) @(posedge clk_sys);
        if (done !== 1'b1) hang();
        r = q[32] ? longint'($signed(v)) : longint'($signed(v[15:0]));
        f = i2f(r);
        if (!q[33]) r = f2i(v, q[32], err);
        lo_m = q[33] ? f[15:0] : r[15:0];
        if (q[33] || q[32]) hi_m = q[33] ? f[31:16] : r[31:16];
        fl = q[33] ? {f[31], f[30:0] == 31'h0, 1'b0} : {r < 0, r == 0, err};
        rd(OFF_RES_LO, got);
        chk_word("result low", 32'(lo_m), got);
        rd(OFF_RES_HI, got);
        chk_word("result high", 32'(hi_m), got);
        rd(OFF_FLAGS, got);
        chk_word("flags", 32'(fl), got);
    endtask
    // Reset, directed and random conversions, then interrupt handling
    initial
    begin
        void'($urandom(4338));
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        wr(OFF_IRQ_MASK, 32'h3);
        repeat (24)
        begin
            p = {2'($urandom), $urandom};
            if (!p[33]) p[30:23] = 8'(110 + $urandom_range(84));
            plan.push_back(p);
        end
        foreach (plan[i]) run(plan[i]);
        chk_bit("irq", 1'b1, irq);
        rd(OFF_IRQ_STAT, got);
        chk_word("status", 32'h3, got);
        wr(OFF_IRQ_STAT, 32'h3);
        rd(OFF_IRQ_STAT, got);
        chk_word("status", 32'h0, got);
        chk_bit("irq", 1'b0, irq);
        wr(OFF_IRQ_MASK, 32'h0);
        run({2'd2, 32'h00000005});
        chk_bit("irq", 1'b0, irq);
        rd(OFF_IRQ_STAT, got);
        chk_word("status", 32'h1, got);
        wr(OFF_CMD, 32'h1c6);
        repeat (2) @(posedge clk_sys);
        chk_bit("done", 1'b0, done);
        wr(OFF_RES_LO, 32'hffff);
        rd(OFF_RES_LO, got);
        chk_word("result low", 32'(lo_m), got);
        end_of_test();
    end
endmodule // float_int_converter_bench

bind float_int_converter fconv_sva chk (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ), .DONE(DONE));

// *** test/seq_master.sv ***
// Bus master standing in for the instruction sequencer.
// Assumes a slave that answers each request with one low waitrequest cycle.
module seq_master (
    input wire logic clk,
    input wire logic waitrequest,
    input wire logic [31:0] readdata,
    output logic [4:0] address,
    output logic read,
    output logic write,
    output logic [31:0] writedata,
    output logic [3:0] byteenable
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero; all byte lanes always enabled
    initial {address, read, write, writedata, byteenable} = {39'h0, 4'hf};
    // One bus cycle; request held until waitrequest is seen low at an edge
    task automatic xfer(input bit is_wr, input logic [4:0] a, input logic [31:0] d,
        output logic [31:0] q, output bit to);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        writedata <= d;
        read <= !is_wr;
        write <= is_wr;
        do @(posedge clk); while (waitrequest !== 1'b0 && n++ < 20);
        to = waitrequest !== 1'b0;
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        writedata <= ~d; // Released data toggles so a stale word is never read as valid
    endtask
endmodule // seq_master

// *** verilog/fconv_pkg.sv ***
// Constants and types for the float/integer conversion datapath.
// Assumes a single 40 MHz system clock and a 32-bit Avalon-MM register slave.
package fconv_pkg;

    // Register byte offsets, one aligned 32-bit word each
    localparam logic [4:0] OFF_SRC_LO = 5'h00;
    localparam logic [4:0] OFF_SRC_HI = 5'h04;
    localparam logic [4:0] OFF_CMD = 5'h08;
    localparam logic [4:0] OFF_RES_LO = 5'h0c;
    localparam logic [4:0] OFF_RES_HI = 5'h10;
    localparam logic [4:0] OFF_FLAGS = 5'h14;
    localparam logic [4:0] OFF_IRQ_STAT = 5'h18;
    localparam logic [4:0] OFF_IRQ_MASK = 5'h1c;

    // Operation codes written to the command register
    localparam logic [8:0] OP_FLOAT_TO_INT16 = 9'h1c2;
    localparam logic [8:0] OP_FLOAT_TO_INT32 = 9'h1c3;
    localparam logic [8:0] OP_INT16_TO_FLOAT = 9'h1c4;
    localparam logic [8:0] OP_INT32_TO_FLOAT = 9'h1c5;

    // Command register field positions
    localparam int CMD_BUSY_BIT = 16;

    // Single-precision layout
    localparam int FRAC_W = 23;
    localparam logic [7:0] EXP_BIAS = 8'h7f;
    localparam logic [7:0] EXP_ALL_ONES = 8'hff;
    localparam logic [7:0] LAST_SHIFT = 8'h1f;

    // Magnitude limits of the signed integer ranges
    localparam logic [31:0] INT16_POS_MAX = 32'h0000_7fff;
    localparam logic [31:0] INT16_NEG_MAX = 32'h0000_8000;
    localparam logic [31:0] INT32_POS_MAX = 32'h7fff_ffff;
    localparam logic [31:0] INT32_NEG_MAX = 32'h8000_0000;

    // Interrupt status and mask bit positions
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_ERR_BIT = 1;

    // Reset values
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [1:0] RST_IRQ = 2'h0;
    localparam logic [8:0] RST_OP = 9'h000;

    // Condition flags; error sits in bit 0 of the flags register
    typedef struct packed {
        logic negative;
        logic zero_result_flag;
        logic error_flag;
    } flags_t;

    // One finished conversion
    typedef struct packed {
        logic [15:0] hi;
        logic [15:0] lo;
        logic write_hi;
        flags_t flags;
    } conv_res_t;

    typedef enum logic {
        ST_IDLE,
        ST_CONVERT
    } conv_state_t;

endpackage

// *** verilog/float_int_converter.sv ***
// Float/integer conversion datapath with an Avalon-MM register slave.
// Assumes a master that holds each request until it sees waitrequest low,
// one synchronous clock and a synchronous active-low reset.

// Behaviour
// - Code 450 turns the two-word float into one 16-bit signed word.
// - Float to integer truncates toward zero for both signs.
// - Code 451 gives a 32-bit signed result, upper half in high word.
// - Code 450 raises error outside -32768 to 32767.
// - Code 451 raises error outside the 32-bit signed range.
// - NaN or out-of-range source raises error; otherwise error is cleared.
// - Float to integer sets the zero flag when the result is zero.
// - Float to integer sets negative from the result's top bit.
// - Code 452 turns one 16-bit signed word into a two-word float.
// - Code 453 turns a two-word 32-bit integer into a two-word float.
// - Magnitudes above 24 bits are rounded, smaller ones exact.
// - Integer to float sets zero when exponent and fraction are zero.
// - Integer to float sets negative when the result is negative.
// - Float layout is sign, 8-bit exponent biased 127, 23-bit fraction.
// - Exponent all ones with nonzero fraction is a NaN.
// - Round to nearest, ties to an even last fraction bit.
module float_int_converter
    import fconv_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic [4:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic IRQ,
    output logic DONE
);

    // Truncated integer magnitude of a float; bit 32 marks 2^32 or more
    // Exponents below the bias give zero, which covers denormals and -0.0 too
    function automatic logic [32:0] trunc_mag(input logic [7:0] e, input logic [22:0] f);
        logic [55:0] wide;
        logic [7:0] sh;
        wide = {32'h0000_0000, 1'b1, f};
        sh = 8'h00;
        trunc_mag = 33'h0_0000_0000;
        if (e >= EXP_BIAS)
        begin
            sh = e - EXP_BIAS;
            // Beyond 31 shifts the magnitude no longer fits; flag it as too big
            if (sh > LAST_SHIFT)
            begin
                trunc_mag = {1'b1, 32'h0000_0000};
            end
            else
            begin
                wide = wide << sh;
                trunc_mag = {1'b0, wide[FRAC_W + 31:FRAC_W]};
            end
        end
    endfunction

    // Signed 32-bit integer to single precision, round to nearest even
    function automatic logic [31:0] to_float(input logic [31:0] v);
        logic s;
        logic [31:0] mag;
        logic [31:0] norm;
        logic [4:0] p;
        logic rnd;
        logic [30:0] body;
        s = v[31];
        mag = s ? (32'h0000_0000 - v) : v;
        p = 5'h00;
        norm = 32'h0000_0000;
        rnd = 1'b0;
        body = 31'h0000_0000;
        // Leading-one search; the last hit is the highest set bit
        for (int i = 0; i < 32; i++)
        begin
            if (mag[i])
            begin
                p = 5'(i);
            end
        end
        norm = mag << (5'h1f - p);
        // Guard bit, sticky bits and last kept bit decide the rounding
        rnd = norm[7] && ((|norm[6:0]) || norm[8]);
        // A fraction carry out bumps the exponent for free
        body = {EXP_BIAS + {3'h0, p}, norm[30:8]} + {30'h0000_0000, rnd};
        // Zero has no leading one, so it is forced to +0.0 here
        to_float = (mag == 32'h0000_0000) ? 32'h0000_0000 : {s, body};
    endfunction

    // Apply byte enables to the low half-word of a register
    // Only lanes 0 and 1 carry register bits; upper lanes are ignored
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    // Software-visible source and result words
    logic [15:0] src_lo_r;
    logic [15:0] src_hi_r;
    logic [15:0] res_lo_r;
    logic [15:0] res_hi_r;

    // Sequencer state and the flags it produces
    logic [8:0] op_r;
    flags_t flags_r;
    conv_state_t state_r;

    // Interrupt state and the registered bus outputs
    logic [1:0] stat_r;
    logic [1:0] mask_r;
    logic wait_r;
    logic [31:0] rdata_r;
    logic irq_r;
    logic done_r;

    // Bus decode: each request waits one cycle, then is accepted
    // Read data is loaded into a flip-flop before acceptance, so every access
    // pays one wait state in exchange for a registered read port
    wire logic req = AVS_READ | AVS_WRITE;
    wire logic accept = req && !wait_r;
    wire logic wr_acc = accept && AVS_WRITE;
    wire logic wr_src_lo = wr_acc && (AVS_ADDRESS == OFF_SRC_LO);
    wire logic wr_src_hi = wr_acc && (AVS_ADDRESS == OFF_SRC_HI);
    wire logic wr_cmd = wr_acc && (AVS_ADDRESS == OFF_CMD) && (AVS_BYTEENABLE[1:0] == 2'h3);
    wire logic wr_stat = wr_acc && (AVS_ADDRESS == OFF_IRQ_STAT) && AVS_BYTEENABLE[0];
    wire logic wr_mask = wr_acc && (AVS_ADDRESS == OFF_IRQ_MASK) && AVS_BYTEENABLE[0];

    // Only the four known codes start a conversion; others are dropped
    // A conversion lasts one cycle, so the sequencer is always idle again
    // before the bus can accept the next command write
    wire logic [8:0] cmd_code = AVS_WRITEDATA[8:0];
    wire logic code_ok = (cmd_code == OP_FLOAT_TO_INT16) || (cmd_code == OP_FLOAT_TO_INT32)
                         || (cmd_code == OP_INT16_TO_FLOAT) || (cmd_code == OP_INT32_TO_FLOAT);
    wire logic start = wr_cmd && code_ok && (state_r == ST_IDLE);

    // Float source split into its fields, upper half in the high word
    // The whole float-to-integer path is combinational; it settles while
    // the sequencer sits in its convert state
    wire logic [31:0] src_word = {src_hi_r, src_lo_r};
    wire logic f_sign = src_word[31];
    wire logic [7:0] f_exp = src_word[30:23];
    wire logic [22:0] f_frac = src_word[22:0];
    wire logic f_nan = (f_exp == EXP_ALL_ONES) && (f_frac != 23'h00_0000);
    wire logic [32:0] f_mag = trunc_mag(f_exp, f_frac);
    wire logic [31:0] f_int = f_sign ? (32'h0000_0000 - f_mag[31:0]) : f_mag[31:0];

    // Range checks on the truncated value; infinity lands in the too-big case
    wire logic [31:0] lim16 = f_sign ? INT16_NEG_MAX : INT16_POS_MAX;
    wire logic [31:0] lim32 = f_sign ? INT32_NEG_MAX : INT32_POS_MAX;
    wire logic fits16 = !f_mag[32] && (f_mag[31:0] <= lim16);
    wire logic fits32 = !f_mag[32] && (f_mag[31:0] <= lim32);
    wire logic err16 = f_nan || !fits16;
    wire logic err32 = f_nan || !fits32;

    // On error the result saturates to the signed limit, and a NaN gives zero,
    // so software that ignores the error flag at least sees a sane value
    wire logic [15:0] sat16 = f_sign ? INT16_NEG_MAX[15:0] : INT16_POS_MAX[15:0];
    wire logic [31:0] sat32 = f_sign ? INT32_NEG_MAX : INT32_POS_MAX;
    wire logic [15:0] int16_res = f_nan ? RST_WORD : (err16 ? sat16 : f_int[15:0]);
    wire logic [31:0] int32_res = f_nan ? {RST_WORD, RST_WORD}
                                        : (err32 ? sat32 : f_int);

    // Integer sources; the 16-bit one is sign extended first
    // The most negative 32-bit value still has a 32-bit magnitude, so no overflow
    wire logic [31:0] i16_ext = {{16{src_lo_r[15]}}, src_lo_r};
    wire logic [31:0] float_src = (op_r == OP_INT16_TO_FLOAT) ? i16_ext : src_word;
    wire logic [31:0] float_res = to_float(float_src);

    // Flags for each family of operations
    // Zero and negative follow the saturated value that is stored, not the input
    flags_t flags_f16;
    flags_t flags_f32;
    flags_t flags_i2f;
    assign flags_f16.error_flag = err16;
    assign flags_f16.zero_result_flag = (int16_res == RST_WORD);
    assign flags_f16.negative = int16_res[15];
    assign flags_f32.error_flag = err32;
    assign flags_f32.zero_result_flag = (int32_res == {RST_WORD, RST_WORD});
    assign flags_f32.negative = int32_res[31];
    assign flags_i2f.error_flag = 1'b0;
    assign flags_i2f.zero_result_flag = (float_res[30:0] == 31'h0000_0000);
    assign flags_i2f.negative = float_res[31];

    // Result selection by the latched operation code
    // The 16-bit result leaves the high result word as it was
    conv_res_t conv;
    wire logic is_f16 = (op_r == OP_FLOAT_TO_INT16);
    wire logic is_f32 = (op_r == OP_FLOAT_TO_INT32);
    assign conv.lo = is_f16 ? int16_res : (is_f32 ? int32_res[15:0] : float_res[15:0]);
    assign conv.hi = is_f32 ? int32_res[31:16] : float_res[31:16];
    assign conv.write_hi = !is_f16;
    assign conv.flags = is_f16 ? flags_f16 : (is_f32 ? flags_f32 : flags_i2f);

    wire logic finish = (state_r == ST_CONVERT);

    // Interrupt status: a new event wins over a write-one-to-clear in the same cycle
    logic [1:0] stat_set;
    assign stat_set[STAT_DONE_BIT] = finish;
    assign stat_set[STAT_ERR_BIT] = finish && conv.flags.error_flag;
    wire logic [1:0] stat_clr = wr_stat ? AVS_WRITEDATA[1:0] : 2'h0;
    wire logic [1:0] stat_nxt = (stat_r & ~stat_clr) | stat_set;
    wire logic [1:0] mask_nxt = wr_mask ? AVS_WRITEDATA[1:0] : mask_r;

    // Read multiplexer; unmapped addresses read as zero
    // Reads have no side effects, so software may poll any word freely
    logic [31:0] rd_mux;
    always_comb
    begin
        case (AVS_ADDRESS)
            OFF_SRC_LO: rd_mux = {16'h0000, src_lo_r};
            OFF_SRC_HI: rd_mux = {16'h0000, src_hi_r};
            OFF_CMD:
            begin
                rd_mux = {23'h00_0000, op_r};
                rd_mux[CMD_BUSY_BIT] = finish;
            end
            OFF_RES_LO: rd_mux = {16'h0000, res_lo_r};
            OFF_RES_HI: rd_mux = {16'h0000, res_hi_r};
            OFF_FLAGS: rd_mux = {29'h0000_0000, flags_r};
            OFF_IRQ_STAT: rd_mux = {30'h0000_0000, stat_r};
            OFF_IRQ_MASK: rd_mux = {30'h0000_0000, mask_r};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Bus handshake: waitrequest drops for exactly one cycle per request
    // A master that drops its request before acceptance only loses that access
    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
        begin
            wait_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            wait_r <= !(req && wait_r);
            if (req && wait_r)
            begin
                rdata_r <= rd_mux;
            end
        end
    end

    // Source words, written by software before the command
    // Byte enables let software patch one byte of a source word
    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
        begin
            src_lo_r <= RST_WORD;
            src_hi_r <= RST_WORD;
        end
        else
        begin
            if (wr_src_lo)
            begin
                src_lo_r <= merge16(src_lo_r, AVS_WRITEDATA, AVS_BYTEENABLE);
            end
            if (wr_src_hi)
            begin
                src_hi_r <= merge16(src_hi_r, AVS_WRITEDATA, AVS_BYTEENABLE);
            end
        end
    end

    // Sequencer: start latches the code, the next edge stores the result
    // One convert cycle suffices because the datapath is purely combinational
    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
        begin
            state_r <= ST_IDLE;
            op_r <= RST_OP;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        op_r <= cmd_code;
                        state_r <= ST_CONVERT;
                    end
                end
                ST_CONVERT: state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Result words and flags land together with the done pulse
    // Flags are stored as one word so software never sees a mixed set
    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
        begin
            res_lo_r <= RST_WORD;
            res_hi_r <= RST_WORD;
            flags_r <= '0;
            done_r <= 1'b0;
        end
        else
        begin
            done_r <= finish;
            if (finish)
            begin
                res_lo_r <= conv.lo;
                flags_r <= conv.flags;
                if (conv.write_hi)
                begin
                    res_hi_r <= conv.hi;
                end
            end
        end
    end

    // Interrupt state; the output follows the next status so it is registered
    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
        begin
            stat_r <= RST_IRQ;
            mask_r <= RST_IRQ;
            irq_r <= 1'b0;
        end
        else
        begin
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            irq_r <= |(stat_nxt & mask_nxt);
        end
    end

    // Output ports are plain copies of flip-flops
    assign AVS_READDATA = rdata_r;
    assign AVS_WAITREQUEST = wait_r;
    assign IRQ = irq_r;
    assign DONE = done_r;

endmodule // float_int_converter
